/* hash_unit.sv */
/*
 * Coprocessor hash unit: message and chaining-value storage loaded by
 * coprocessor moves, access checks, and MD5/SHA-1 block starts.
 * Assumes the core holds a move until cop_ready and treats the
 * exception pulses as the outcome of the move taken one cycle earlier.
 */
module hash_unit
    import hash_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic cop_valid,
    input wire logic [15:0] cop_selector,
    input wire logic [WORD_W-1:0] source_operand,
    input wire logic cop2_enabled,
    input wire logic ops64_enabled,
    input wire logic crypto_disable_bit,
    output logic cop_ready,
    output logic exc_coproc_unusable,
    output logic exc_reserved_instr,
    output logic hash_done,
    output logic [MSG_WORDS-1:0][WORD_W-1:0] message_block_words,
    output logic [CV_WORDS-1:0][WORD_W-1:0] chaining_value_words
);

    typedef struct packed {
        logic [MSG_WORDS-1:0][WORD_W-1:0] msg;
        logic [CV_WORDS-1:0][WORD_W-1:0] cv;
        logic exc_cu;
        logic exc_ri;
        logic done;
        logic algo;
    } unit_s;

    unit_s s;
    unit_s next_s;

    function automatic op_e decode_op(input logic [15:0] sel);
        if (sel >= SEL_MSG_NARROW_BASE && sel <= SEL_MSG_NARROW_LAST) begin
            return OP_MSG_NARROW;
        end else if (sel >= SEL_CV_NARROW_BASE && sel <= SEL_CV_NARROW_LAST) begin
            return OP_CV_NARROW;
        end else if (sel >= SEL_MSG_WIDE_BASE && sel <= SEL_MSG_WIDE_LAST) begin
            return OP_MSG_WIDE;
        end else if (sel >= SEL_CV_WIDE_BASE && sel <= SEL_CV_WIDE_LAST) begin
            return OP_CV_WIDE;
        end else if (sel == SEL_START_MD5) begin
            return OP_START_MD5;
        end else if (sel == SEL_START_SHA1) begin
            return OP_START_SHA1;
        end else begin
            return OP_NONE;
        end
    endfunction

    function automatic logic [31:0] bswap32(input logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction

    op_e op;
    logic take;
    logic legal;
    logic eng_start;
    logic eng_busy;
    logic eng_done;
    logic start_algo;
    logic [15:0] offset;
    logic [BLOCK_W-1:0] assembled_block;
    logic [CV_BUS_W-1:0] assembled_chaining;
    logic [CV_BUS_W-1:0] eng_result;

    // a move is held off until a compression has written back; the chaining words it could
    // touch are still to be overwritten by the result, so the core simply stalls
    assign cop_ready = clk_en && !eng_busy && !eng_done;
    assign take = cop_valid && cop_ready;
    assign op = decode_op(cop_selector);
    assign offset = cop_selector - ((op == OP_MSG_NARROW) ? SEL_MSG_NARROW_BASE :
                                    (op == OP_CV_NARROW) ? SEL_CV_NARROW_BASE :
                                    (op == OP_MSG_WIDE) ? SEL_MSG_WIDE_BASE :
                                    SEL_CV_WIDE_BASE);
    assign legal = cop2_enabled && ops64_enabled && !crypto_disable_bit;
    assign start_algo = (op == OP_START_SHA1) ? ALGO_SHA1 : ALGO_MD5;
    assign eng_start = take && legal && (op == OP_START_MD5 || op == OP_START_SHA1);

    // block words 0-13 and chaining input come from low halves; words 14-15 from source_operand
    always_comb begin
        for (int i = 0; i < NARROW_MSG_WORDS; i++) begin
            assembled_block[BLOCK_W-1-HALF_W*i -: HALF_W] = (start_algo == ALGO_MD5) ?
                bswap32(s.msg[i][HALF_W-1:0]) : s.msg[i][HALF_W-1:0];
        end
        assembled_block[2*HALF_W-1:HALF_W] = (start_algo == ALGO_MD5) ?
            bswap32(source_operand[63:32]) : source_operand[63:32];
        assembled_block[HALF_W-1:0] = (start_algo == ALGO_MD5) ?
            bswap32(source_operand[31:0]) : source_operand[31:0];
        for (int i = 0; i < SHA1_WORDS_USED; i++) begin
            assembled_chaining[CV_BUS_W-1-HALF_W*i -: HALF_W] = (start_algo == ALGO_MD5) ?
                bswap32(s.cv[i][HALF_W-1:0]) : s.cv[i][HALF_W-1:0];
        end
    end

    always_comb begin
        next_s = s;
        next_s.exc_cu = 1'b0;
        next_s.exc_ri = 1'b0;
        next_s.done = 1'b0;
        if (take && op != OP_NONE) begin
            if (!cop2_enabled) begin
                next_s.exc_cu = 1'b1;
            end else if (!ops64_enabled) begin
                next_s.exc_ri = 1'b1;
            end else if (crypto_disable_bit) begin
                next_s.exc_ri = 1'b1;
            end else begin
                case (op)
                    OP_MSG_NARROW: begin
                        // upper halves are undefined; zero is our pick
                        next_s.msg[2*offset[2:0]] = {HALF_UNDEF, source_operand[63:32]};
                        next_s.msg[2*offset[2:0]+1] = {HALF_UNDEF, source_operand[31:0]};
                    end
                    OP_CV_NARROW: begin
                        next_s.cv[2*offset[1:0]] = {HALF_UNDEF, source_operand[63:32]};
                        next_s.cv[2*offset[1:0]+1] = {HALF_UNDEF, source_operand[31:0]};
                    end
                    OP_MSG_WIDE: begin
                        next_s.msg[offset[3:0]] = source_operand;
                    end
                    OP_CV_WIDE: begin
                        next_s.cv[offset[2:0]] = source_operand;
                    end
                    OP_START_MD5, OP_START_SHA1: begin
                        next_s.algo = start_algo;
                    end
                    default: begin
                        next_s.algo = s.algo;
                    end
                endcase
            end
        end
        if (eng_done) begin
            next_s.done = 1'b1;
            if (s.algo == ALGO_MD5) begin
                for (int i = 0; i < MD5_WORDS_USED; i++) begin
                    next_s.cv[i] = {HALF_UNDEF,
                        bswap32(eng_result[CV_BUS_W-1-HALF_W*i -: HALF_W])};
                end
            end else begin
                for (int i = 0; i < SHA1_WORDS_USED; i++) begin
                    next_s.cv[i] = {HALF_UNDEF,
                        eng_result[CV_BUS_W-1-HALF_W*i -: HALF_W]};
                end
            end
            // message words become undefined; they are left as they were
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    hash_round_engine u_engine (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(eng_start),
        .algo(start_algo),
        .block(assembled_block),
        .iv_in(assembled_chaining),
        .busy(eng_busy),
        .done(eng_done),
        .result(eng_result)
    );

    assign exc_coproc_unusable = s.exc_cu;
    assign exc_reserved_instr = s.exc_ri;
    assign hash_done = s.done;
    assign message_block_words = s.msg;
    assign chaining_value_words = s.cv;

endmodule // hash_unit

/* hash_pkg.sv */
/*
 * Shared constants and types of the coprocessor hash unit: selector
 * codes, word geometry, round counts, operation and state encodings,
 * and the round-constant tables.
 * Assumes a single clock domain and the core's 16-bit move selector.
 */
package hash_pkg;

    localparam int WORD_W = 64;
    localparam int HALF_W = 32;
    localparam int MSG_WORDS = 15;
    localparam int CV_WORDS = 8;
    localparam int NARROW_MSG_WORDS = 14;
    localparam int BLOCK_W = 512;
    localparam int CV_BUS_W = 160;

    localparam logic [15:0] SEL_MSG_NARROW_BASE = 16'h0040;
    localparam logic [15:0] SEL_MSG_NARROW_LAST = 16'h0046;
    localparam logic [15:0] SEL_CV_NARROW_BASE = 16'h0048;
    localparam logic [15:0] SEL_CV_NARROW_LAST = 16'h004B;
    localparam logic [15:0] SEL_MSG_WIDE_BASE = 16'h0240;
    localparam logic [15:0] SEL_MSG_WIDE_LAST = 16'h024E;
    localparam logic [15:0] SEL_CV_WIDE_BASE = 16'h0250;
    localparam logic [15:0] SEL_CV_WIDE_LAST = 16'h0257;
    localparam logic [15:0] SEL_START_MD5 = 16'h4047;
    localparam logic [15:0] SEL_START_SHA1 = 16'h4057;

    localparam logic [63:0] WORD_RESET = 64'h0;
    localparam logic [31:0] HALF_UNDEF = 32'h0;
    localparam int MD5_WORDS_USED = 4;
    localparam int SHA1_WORDS_USED = 5;
    localparam logic [6:0] MD5_LAST_ROUND = 7'h3F;
    localparam logic [6:0] SHA1_LAST_ROUND = 7'h4F;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_MSG_NARROW = 3'b001,
        OP_CV_NARROW = 3'b010,
        OP_MSG_WIDE = 3'b011,
        OP_CV_WIDE = 3'b100,
        OP_START_MD5 = 3'b101,
        OP_START_SHA1 = 3'b110
    } op_e;

    typedef enum logic {
        ALGO_MD5 = 1'b0,
        ALGO_SHA1 = 1'b1
    } algo_e;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_RUN = 2'b01,
        ENG_FINISH = 2'b10
    } eng_state_e;

    localparam logic [31:0] MD5_K [64] = '{
        32'hD76AA478, 32'hE8C7B756, 32'h242070DB, 32'hC1BDCEEE,
        32'hF57C0FAF, 32'h4787C62A, 32'hA8304613, 32'hFD469501,
        32'h698098D8, 32'h8B44F7AF, 32'hFFFF5BB1, 32'h895CD7BE,
        32'h6B901122, 32'hFD987193, 32'hA679438E, 32'h49B40821,
        32'hF61E2562, 32'hC040B340, 32'h265E5A51, 32'hE9B6C7AA,
        32'hD62F105D, 32'h02441453, 32'hD8A1E681, 32'hE7D3FBC8,
        32'h21E1CDE6, 32'hC33707D6, 32'hF4D50D87, 32'h455A14ED,
        32'hA9E3E905, 32'hFCEFA3F8, 32'h676F02D9, 32'h8D2A4C8A,
        32'hFFFA3942, 32'h8771F681, 32'h6D9D6122, 32'hFDE5380C,
        32'hA4BEEA44, 32'h4BDECFA9, 32'hF6BB4B60, 32'hBEBFBC70,
        32'h289B7EC6, 32'hEAA127FA, 32'hD4EF3085, 32'h04881D05,
        32'hD9D4D039, 32'hE6DB99E5, 32'h1FA27CF8, 32'hC4AC5665,
        32'hF4292244, 32'h432AFF97, 32'hAB9423A7, 32'hFC93A039,
        32'h655B59C3, 32'h8F0CCC92, 32'hFFEFF47D, 32'h85845DD1,
        32'h6FA87E4F, 32'hFE2CE6E0, 32'hA3014314, 32'h4E0811A1,
        32'hF7537E82, 32'hBD3AF235, 32'h2AD7D2BB, 32'hEB86D391
    };

    localparam logic [4:0] MD5_S [16] = '{
        5'h07, 5'h0C, 5'h11, 5'h16, 5'h05, 5'h09, 5'h0E, 5'h14,
        5'h04, 5'h0B, 5'h10, 5'h17, 5'h06, 5'h0A, 5'h0F, 5'h15
    };

    localparam logic [31:0] SHA1_K [4] = '{
        32'h5A827999, 32'h6ED9EBA1, 32'h8F1BBCDC, 32'hCA62C1D6
    };

endpackage

/* hash_round_engine.sv */
/*
 * Iterative compression core: one MD5 or SHA-1 round per enabled clock.
 * Assumes the caller holds block and chaining input stable only in the
 * start cycle (they are captured) and byte-orders them for the algorithm.
 */
module hash_round_engine
    import hash_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic start,
    input wire logic algo,
    input wire logic [BLOCK_W-1:0] block,
    input wire logic [CV_BUS_W-1:0] iv_in,
    output logic busy,
    output logic done,
    output logic [CV_BUS_W-1:0] result
);

    typedef struct packed {
        eng_state_e state;
        logic algo;
        logic [6:0] round;
        logic [15:0][31:0] w;
        logic [4:0][31:0] h;
        logic [4:0][31:0] v;
        logic [CV_BUS_W-1:0] result;
        logic done;
    } engine_s;

    engine_s s;
    engine_s next_s;

    function automatic logic [31:0] rotl(input logic [31:0] x, input logic [4:0] n);
        logic [63:0] t;
        t = {x, x} << n;
        return t[63:32];
    endfunction

    logic [31:0] f;
    logic [31:0] sum;
    logic [3:0] g;
    logic [1:0] grp;
    logic [6:0] last;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        f = 32'h0;
        sum = 32'h0;
        g = 4'h0;
        grp = 2'h0;
        last = (s.algo == ALGO_SHA1) ? SHA1_LAST_ROUND : MD5_LAST_ROUND;
        case (s.state)
            ENG_IDLE: begin
                if (start) begin
                    next_s.state = ENG_RUN;
                    next_s.algo = algo;
                    next_s.round = 7'h0;
                    for (int i = 0; i < 16; i++) begin
                        next_s.w[i] = block[BLOCK_W-1-32*i -: 32];
                    end
                    for (int i = 0; i < 5; i++) begin
                        next_s.h[i] = iv_in[CV_BUS_W-1-32*i -: 32];
                        next_s.v[i] = iv_in[CV_BUS_W-1-32*i -: 32];
                    end
                end
            end
            ENG_RUN: begin
                if (s.algo == ALGO_MD5) begin
                    grp = s.round[5:4];
                    case (grp)
                        2'h0: begin
                            f = (s.v[1] & s.v[2]) | (~s.v[1] & s.v[3]);
                            g = s.round[3:0];
                        end
                        2'h1: begin
                            f = (s.v[3] & s.v[1]) | (~s.v[3] & s.v[2]);
                            g = 4'(s.round[3:0] * 4'h5 + 4'h1);
                        end
                        2'h2: begin
                            f = s.v[1] ^ s.v[2] ^ s.v[3];
                            g = 4'(s.round[3:0] * 4'h3 + 4'h5);
                        end
                        default: begin
                            f = s.v[2] ^ (s.v[1] | ~s.v[3]);
                            g = 4'(s.round[3:0] * 4'h7);
                        end
                    endcase
                    sum = s.v[0] + f + MD5_K[s.round[5:0]] + s.w[g];
                    next_s.v[0] = s.v[3];
                    next_s.v[3] = s.v[2];
                    next_s.v[2] = s.v[1];
                    next_s.v[1] = s.v[1] + rotl(sum, MD5_S[{grp, s.round[1:0]}]);
                end else begin
                    if (s.round < 7'd20) begin
                        f = (s.v[1] & s.v[2]) | (~s.v[1] & s.v[3]);
                        grp = 2'h0;
                    end else if (s.round < 7'd40) begin
                        f = s.v[1] ^ s.v[2] ^ s.v[3];
                        grp = 2'h1;
                    end else if (s.round < 7'd60) begin
                        f = (s.v[1] & s.v[2]) | (s.v[1] & s.v[3]) | (s.v[2] & s.v[3]);
                        grp = 2'h2;
                    end else begin
                        f = s.v[1] ^ s.v[2] ^ s.v[3];
                        grp = 2'h3;
                    end
                    sum = rotl(s.v[0], 5'h05) + f + s.v[4] + SHA1_K[grp] + s.w[0];
                    next_s.v[4] = s.v[3];
                    next_s.v[3] = s.v[2];
                    next_s.v[2] = rotl(s.v[1], 5'h1E);
                    next_s.v[1] = s.v[0];
                    next_s.v[0] = sum;
                    // schedule window slides; w[0] is always the current word
                    next_s.w = {rotl(s.w[13] ^ s.w[8] ^ s.w[2] ^ s.w[0], 5'h01), s.w[15:1]};
                end
                next_s.round = s.round + 7'h1;
                if (s.round == last) begin
                    next_s.state = ENG_FINISH;
                end
            end
            ENG_FINISH: begin
                for (int i = 0; i < 5; i++) begin
                    next_s.result[CV_BUS_W-1-32*i -: 32] = s.h[i] + s.v[i];
                end
                next_s.done = 1'b1;
                next_s.state = ENG_IDLE;
            end
            default: begin
                next_s.state = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign busy = (s.state != ENG_IDLE);
    assign done = s.done;
    assign result = s.result;

endmodule // hash_round_engine

/* hash_unit_props.sv */
/* hash_unit_props: port assertions for the coprocessor hash unit.
   assumes one clock and a synchronous active-high reset. */
module hash_unit_props
    import hash_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic cop_valid,
    input wire logic [15:0] cop_selector,
    input wire logic [WORD_W-1:0] source_operand,
    input wire logic cop2_enabled,
    input wire logic ops64_enabled,
    input wire logic crypto_disable_bit,
    input wire logic cop_ready,
    input wire logic exc_coproc_unusable,
    input wire logic exc_reserved_instr,
    input wire logic hash_done,
    input wire logic [MSG_WORDS-1:0][WORD_W-1:0] message_block_words,
    input wire logic [CV_WORDS-1:0][WORD_W-1:0] chaining_value_words
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic tk;
    logic ok;
    logic inr;
    assign tk = cop_valid && cop_ready;
    assign ok = cop2_enabled && ops64_enabled && !crypto_disable_bit;
    assign inr = cop_selector inside {[SEL_MSG_NARROW_BASE:SEL_MSG_NARROW_LAST],
        [SEL_CV_NARROW_BASE:SEL_CV_NARROW_LAST], [SEL_MSG_WIDE_BASE:SEL_MSG_WIDE_LAST],
        [SEL_CV_WIDE_BASE:SEL_CV_WIDE_LAST], SEL_START_MD5, SEL_START_SHA1};
    sequence s_start;
        tk && ok && (cop_selector == SEL_START_MD5 || cop_selector == SEL_START_SHA1);
    endsequence
    sequence s_busy;
        !cop_ready [*8];
    endsequence
    AST_MSG_WIDE: assert property (tk && ok && cop_selector inside
        {[SEL_MSG_WIDE_BASE:SEL_MSG_WIDE_LAST]} |=>
        message_block_words[$past(cop_selector[3:0])] == $past(source_operand))
        else $error("wide message load lost");
    AST_CV_WIDE: assert property (tk && ok && cop_selector inside
        {[SEL_CV_WIDE_BASE:SEL_CV_WIDE_LAST]} |=>
        chaining_value_words[$past(cop_selector[2:0])] == $past(source_operand))
        else $error("wide chaining load lost");
    AST_MSG_NARROW: assert property (tk && ok && cop_selector inside
        {[SEL_MSG_NARROW_BASE:SEL_MSG_NARROW_LAST]} |=>
        message_block_words[{$past(cop_selector[2:0]), 1'b0}][31:0]
        == $past(source_operand[63:32]) &&
        message_block_words[{$past(cop_selector[2:0]), 1'b1}][31:0]
        == $past(source_operand[31:0]))
        else $error("narrow message load lost");
    AST_CV_NARROW: assert property (tk && ok && cop_selector inside
        {[SEL_CV_NARROW_BASE:SEL_CV_NARROW_LAST]} |=>
        chaining_value_words[{$past(cop_selector[1:0]), 1'b0}][31:0]
        == $past(source_operand[63:32]) &&
        chaining_value_words[{$past(cop_selector[1:0]), 1'b1}][31:0]
        == $past(source_operand[31:0]))
        else $error("narrow chaining load lost");
    AST_UNUSABLE: assert property (tk && inr && !cop2_enabled |=>
        exc_coproc_unusable && !exc_reserved_instr && !hash_done &&
        $stable(message_block_words) && $stable(chaining_value_words))
        else $error("unusable exception wrong");
    AST_RESERVED: assert property (tk && inr && cop2_enabled &&
        (!ops64_enabled || crypto_disable_bit) |=> exc_reserved_instr &&
        !exc_coproc_unusable && $stable(message_block_words) && $stable(chaining_value_words))
        else $error("reserved exception wrong");
    AST_IGNORE: assert property (tk && !inr |=>
        !exc_coproc_unusable && !exc_reserved_instr &&
        $stable(message_block_words) && $stable(chaining_value_words))
        else $error("foreign selector had an effect");
    AST_START_BUSY: assert property (s_start |=> s_busy)
        else $error("move accepted during compression");
    AST_START_DONE: assert property (s_start |-> ##[60:120] hash_done)
        else $error("compression never finished");
    AST_START_KEEP: assert property (hash_done |->
        $stable(chaining_value_words[7:5]))
        else $error("unused chaining words changed");
endmodule // hash_unit_props

bind hash_unit hash_unit_props props (.clk(clk), .reset(reset), .clk_en(clk_en),
    .cop_valid(cop_valid), .cop_selector(cop_selector), .source_operand(source_operand),
    .cop2_enabled(cop2_enabled), .ops64_enabled(ops64_enabled),
    .crypto_disable_bit(crypto_disable_bit), .cop_ready(cop_ready),
    .exc_coproc_unusable(exc_coproc_unusable), .exc_reserved_instr(exc_reserved_instr),
    .hash_done(hash_done), .message_block_words(message_block_words),
    .chaining_value_words(chaining_value_words));

/* core_model.sv */
/* core_model: the issuing core, presenting coprocessor moves.
   assumes callers start each move just after a rising edge. */
module core_model
    import hash_pkg::*;
(
    input wire logic clk,
    input wire logic cop_ready,
    output logic cop_valid,
    output logic [15:0] cop_selector,
    output logic [WORD_W-1:0] source_operand
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cop_valid = 1'b0;
        cop_selector = 16'hFFFF;
        source_operand = 64'h0;
    end
    // held until ready is seen at a falling edge; returns on the rising edge after it
    task automatic issue(input logic [15:0] sel, input logic [WORD_W-1:0] op);
        logic rdy;
        cop_valid = 1'b1;
        cop_selector = sel;
        source_operand = op;
        do begin
            @(negedge clk);
            rdy = cop_ready;
            @(posedge clk);
        end while (!rdy);
    endtask
    // released lines show the inverse so stale values cannot pass
    task automatic rest();
        cop_valid = 1'b0;
        cop_selector = ~cop_selector;
        source_operand = ~source_operand;
    endtask
endmodule // core_model

/* hash_unit_tb.sv */
/* hash_unit_tb: self-checking random bench for the hash unit.
   assumes core_model as the core and the bound props checker. */
module hash_unit_tb
    import hash_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic cop2_enabled = 1'b1;
    logic ops64_enabled = 1'b1;
    logic crypto_disable_bit = 1'b0;
    logic cop_valid, cop_ready, exc_coproc_unusable, exc_reserved_instr, hash_done;
    logic [15:0] cop_selector;
    logic [WORD_W-1:0] source_operand;
    logic [MSG_WORDS-1:0][WORD_W-1:0] message_block_words;
    logic [CV_WORDS-1:0][WORD_W-1:0] chaining_value_words;
    logic [WORD_W-1:0] exp_msg [MSG_WORDS] = '{default: 0};
    logic [WORD_W-1:0] exp_cv [CV_WORDS] = '{default: 0};
    // word 0 lowest
    localparam logic [255:0] KAT_IN [2] = '{256'hFEDCBA98765432100123456789ABCDEF,
        256'hC3D2E1F00000000098BADCFE1032547667452301EFCDAB89};
    localparam logic [159:0] KAT_OUT [2] = '{160'hECF8427EE98009988F00B204D41D8CD9,
        160'hAFD80709956018903255BFEF5E6B4B0DDA39A3EE};
    int num_errors = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    core_model core (.clk(clk), .cop_ready(cop_ready), .cop_valid(cop_valid),
        .cop_selector(cop_selector), .source_operand(source_operand));
    hash_unit uut (.clk(clk), .reset(reset), .clk_en(clk_en), .cop_valid(cop_valid),
        .cop_selector(cop_selector), .source_operand(source_operand),
        .cop2_enabled(cop2_enabled), .ops64_enabled(ops64_enabled),
        .crypto_disable_bit(crypto_disable_bit), .cop_ready(cop_ready),
        .exc_coproc_unusable(exc_coproc_unusable), .exc_reserved_instr(exc_reserved_instr),
        .hash_done(hash_done), .message_block_words(message_block_words),
        .chaining_value_words(chaining_value_words));
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check_word(input string what, input logic [WORD_W-1:0] exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_store(input int from_cv);
        for (int i = 0; i < MSG_WORDS; i++) begin
            check_word($sformatf("msg%0d", i), exp_msg[i], message_block_words[i]);
        end
        for (int i = from_cv; i < CV_WORDS; i++) begin
            check_word($sformatf("cv%0d", i), exp_cv[i], chaining_value_words[i]);
        end
    endtask
    // returns {unusable, reserved}; updates the expected store
    function automatic logic [1:0] expect_move(input logic [15:0] s, input logic [63:0] d);
        if (!(s inside {[SEL_MSG_NARROW_BASE:SEL_MSG_NARROW_LAST],
            [SEL_CV_NARROW_BASE:SEL_CV_NARROW_LAST], [SEL_MSG_WIDE_BASE:SEL_MSG_WIDE_LAST],
            [SEL_CV_WIDE_BASE:SEL_CV_WIDE_LAST], SEL_START_MD5, SEL_START_SHA1})) return 2'h0;
        if (!cop2_enabled) return 2'h2;
        if (!ops64_enabled || crypto_disable_bit) return 2'h1;
        if (s <= SEL_MSG_NARROW_LAST) begin
            exp_msg[2 * (s - SEL_MSG_NARROW_BASE)] = {32'h0, d[63:32]};
            exp_msg[2 * (s - SEL_MSG_NARROW_BASE) + 1] = {32'h0, d[31:0]};
        end else if (s <= SEL_CV_NARROW_LAST) begin
            exp_cv[2 * (s - SEL_CV_NARROW_BASE)] = {32'h0, d[63:32]};
            exp_cv[2 * (s - SEL_CV_NARROW_BASE) + 1] = {32'h0, d[31:0]};
        end else if (s <= SEL_MSG_WIDE_LAST) begin
            exp_msg[s - SEL_MSG_WIDE_BASE] = d;
        end else if (s <= SEL_CV_WIDE_LAST) begin
            exp_cv[s - SEL_CV_WIDE_BASE] = d;
        end
        return 2'h0;
    endfunction
    function automatic logic [15:0] pick_sel();
        case ($urandom_range(5))
            0: return SEL_MSG_NARROW_BASE + 16'($urandom_range(6));
            1: return SEL_CV_NARROW_BASE + 16'($urandom_range(3));
            2: return SEL_MSG_WIDE_BASE + 16'($urandom_range(14));
            3: return SEL_CV_WIDE_BASE + 16'($urandom_range(7));
            4: return 16'h0047;
            default: return 16'h024F;
        endcase
    endfunction
    task automatic do_move(input logic [15:0] s, input logic [WORD_W-1:0] d);
        logic [1:0] e;
        e = expect_move(s, d);
        core.issue(s, d);
        #1;
        check_bit("unusable", e[1], exc_coproc_unusable);
        check_bit("reserved", e[0], exc_reserved_instr);
        check_bit("no done", 1'b0, hash_done);
        check_store(0);
    endtask
    task automatic do_start(input logic [15:0] s, input int used);
        int n;
        core.issue(s, 64'h0);
        #1;
        core.rest();
        check_bit("busy", 1'b0, cop_ready);
        n = 0;
        while (hash_done !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_bit("done", 1'b1, hash_done);
        check_bit("ready again", 1'b1, cop_ready);
        for (int i = 0; i < used; i++) begin
            check_word($sformatf("cv%0d upper", i), 64'h0, {32'h0, chaining_value_words[i][63:32]});
        end
        check_store(0);
        // reset after the run has finished
        reset = 1'b1;
        @(posedge clk);
        #1;
        reset = 1'b0;
        exp_msg = '{default: 0};
        exp_cv = '{default: 0};
        @(posedge clk);
        #1;
    endtask
    initial begin
        #100000;
        num_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        give_verdict();
    end
    initial begin
        void'($urandom(13));
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        check_store(0);
        @(posedge clk);
        #1;
        for (int i = 0; i < MSG_WORDS; i++) do_move(SEL_MSG_WIDE_BASE + 16'(i), {$urandom, $urandom});
        for (int i = 0; i < CV_WORDS; i++) do_move(SEL_CV_WIDE_BASE + 16'(i), {$urandom, $urandom});
        for (int i = 0; i < 300; i++) begin
            cop2_enabled = ($urandom_range(7) != 0);
            ops64_enabled = ($urandom_range(7) != 0);
            crypto_disable_bit = ($urandom_range(7) == 0);
            if ($urandom_range(7) == 0) begin
                clk_en = 1'b0;
                fork
                    begin
                        repeat (3) @(posedge clk);
                        #1 clk_en = 1'b1;
                    end
                join_none
            end
            do_move(pick_sel(), {$urandom, $urandom});
        end
        for (int k = 0; k < 3; k++) begin
            cop2_enabled = (k != 0);
            ops64_enabled = (k != 1);
            crypto_disable_bit = (k != 1);
            do_move(k[0] ? SEL_START_SHA1 : SEL_START_MD5, {$urandom, $urandom});
        end
        cop2_enabled = 1'b1;
        ops64_enabled = 1'b1;
        crypto_disable_bit = 1'b0;
        for (int a = 0; a < 2; a++) begin
            for (int j = 0; j < 7; j++) do_move(SEL_MSG_NARROW_BASE + 16'(j), {j == 0, 63'h0});
            for (int j = 0; j < 4; j++) do_move(SEL_CV_NARROW_BASE + 16'(j), KAT_IN[a][64*j +: 64]);
            for (int i = 0; i < 5; i++) exp_cv[i] = {32'h0, KAT_OUT[a][32*i +: 32]};
            do_start(a ? SEL_START_SHA1 : SEL_START_MD5, a ? SHA1_WORDS_USED : MD5_WORDS_USED);
        end
        give_verdict();
    end
endmodule // hash_unit_tb
